/* dv/rsu_status_ctrl_sva.sv */
/* Port checks on the status and control block.
   Assumes one clk domain, sys_rst synchronous and active high. */
`timescale 1ns/100ps
module rsu_status_ctrl_sva
(
    input wire        clk,                // Clock
    input wire        sys_rst,            // Reset
    input wire        ext_config_reset_n, // Ext reset, low
    input wire        load_done,          // Load finished
    input wire        reconfig_start,     // Start pulse
    input wire [1:0]  master_state,       // Master state
    input wire [23:0] boot_address,       // Boot address
    input wire [28:0] watchdog_timeout    // Timeout value
);
default clocking cb @(posedge clk);
endclocking
default disable iff (sys_rst);
property p_pulse; reconfig_start |=> !reconfig_start; endproperty
a_pulse: assert property (p_pulse) else $error("long start");
property p_st; reconfig_start |-> master_state == 2'h2; endproperty
a_st: assert property (p_st) else $error("start not in reload");
property p_go;
    master_state != 2'h2 ##1 master_state == 2'h2 |-> reconfig_start;
endproperty
a_go: assert property (p_go) else $error("reload without start");
property p_wd; watchdog_timeout[16:0] == 17'h0_0008; endproperty
a_wd: assert property (p_wd) else $error("timeout low bits");
property p_ba; boot_address[1:0] == 2'h0; endproperty
a_ba: assert property (p_ba) else $error("address low bits");
property p_ld;
    master_state == 2'h2 && load_done && !reconfig_start |=>
        master_state != 2'h2;
endproperty
a_ld: assert property (p_ld) else $error("reload not ended");
// Boot address may only move at the start of a reload
property p_hold; $changed(boot_address) |-> reconfig_start; endproperty
a_hold: assert property (p_hold) else $error("address moved");
property p_clr;
    master_state != 2'h2 && $fell(ext_config_reset_n) |->
        ##[2:6] (reconfig_start && boot_address == 24'h0);
endproperty
a_clr: assert property (p_clr) else $error("reset not cleared");
endmodule // rsu_status_ctrl_sva
bind rsu_status_ctrl rsu_status_ctrl_sva u_sva
(
    .clk                (clk),
    .sys_rst            (sys_rst),
    .ext_config_reset_n (ext_config_reset_n),
    .load_done          (load_done),
    .reconfig_start     (reconfig_start),
    .master_state       (master_state),
    .boot_address       (boot_address),
    .watchdog_timeout   (watchdog_timeout)
);

/* dv/rsu_user_model.sv */
/* User logic model on the shift interface.
   Assumes the bench clk paces it; the shift clock idles low. */
`timescale 1ns/100ps
module rsu_user_model
(
    input  wire        clk,                 // Bench clock
    input  wire        shift_data_out,      // Serial out
    output logic       upgrade_shift_clock, // Frames only
    output logic       shift_data_in,       // Serial in
    output logic       shift_select,        // 1 shift
    output logic       capture_select,      // 1 capture
    output logic [2:0] read_select          // Word chosen
);
initial {upgrade_shift_clock, shift_data_in, shift_select,
    capture_select, read_select} = 7'h00;
// Pins settle 4 clk before each rise and hold 4 clk after it
task automatic pulse;
    repeat (4) @(negedge clk);
    upgrade_shift_clock = 1'b1;
    repeat (4) @(negedge clk);
    upgrade_shift_clock = 1'b0;
endtask
task automatic rd(input logic [2:0] s, output logic [38:0] v);
    {shift_select, capture_select, read_select} = {2'b01, s};
    pulse;
    shift_select = 1'b1;
    for (int k = 0; k < 39; k++)
    begin
        if (k > 0)
            pulse;
        v[k] = shift_data_out;
    end
endtask
// Low bit first; the idle data line is left inverted
task automatic wr(input logic [38:0] w);
    shift_select = 1'b1;
    for (int k = 0; k < 39; k++)
    begin
        shift_data_in = w[k];
        pulse;
    end
    {shift_select, capture_select} = 2'b00;
    pulse;
    shift_data_in = ~shift_data_in;
endtask
endmodule // rsu_user_model

/* dv/tb_rsu_status_ctrl.sv */
/* Testbench for the status and control block.
   Assumes the user model and the bound checker beside it. */
`timescale 1ns/100ps
`include "rsu_defs.vh"
module tb_rsu_status_ctrl;
logic       clk = 1'b0, sys_rst = 1'b1, load_done = 1'b1;
logic [4:0] src = 5'h00; // Ext reset, crc, status, watchdog, fabric
int         n_mismatch = 0, checks = 0, i;
wire        upgrade_shift_clock, shift_data_in, shift_select;
wire        capture_select, shift_data_out, reconfig_start;
wire        watchdog_enable, early_done_check, startup_osc_select;
wire [2:0]  read_select;
wire [1:0]  master_state;
wire [23:0] boot_address;
wire [28:0] watchdog_timeout;
wire        fabric_reconfig_request = src[0], watchdog_expired = src[1];
wire        config_status_line_n = ~src[2], crc_error = src[3];
wire        ext_config_reset_n = ~src[4];
localparam logic [38:0] W  = 39'h39_2345_6ABC;
localparam logic [23:0] BA = 24'h48_D158;
always #10 clk = ~clk;
rsu_status_ctrl DUT
(
    .clk                     (clk),
    .sys_rst                 (sys_rst),
    .upgrade_shift_clock     (upgrade_shift_clock),
    .shift_data_in           (shift_data_in),
    .shift_select            (shift_select),
    .capture_select          (capture_select),
    .read_select             (read_select),
    .fabric_reconfig_request (fabric_reconfig_request),
    .crc_error               (crc_error),
    .config_status_line_n    (config_status_line_n),
    .ext_config_reset_n      (ext_config_reset_n),
    .watchdog_expired        (watchdog_expired),
    .load_done               (load_done),
    .shift_data_out          (shift_data_out),
    .reconfig_start          (reconfig_start),
    .master_state            (master_state),
    .boot_address            (boot_address),
    .watchdog_enable         (watchdog_enable),
    .watchdog_timeout        (watchdog_timeout),
    .early_done_check        (early_done_check),
    .startup_osc_select      (startup_osc_select)
);
rsu_user_model u
(
    .clk                 (clk),
    .shift_data_out      (shift_data_out),
    .upgrade_shift_clock (upgrade_shift_clock),
    .shift_data_in       (shift_data_in),
    .shift_select        (shift_select),
    .capture_select      (capture_select),
    .read_select         (read_select)
);
////////////////////////////////////////////////////////////
task automatic chk(input logic [38:0] g, e);
    checks++;
    if (g !== e)
    begin
        n_mismatch++;
        $display("wrong value at %0t: %h, expected %h", $time, g, e);
    end
endtask
task automatic rc(input logic [2:0] s, input logic [38:0] e);
    logic [38:0] v;
    u.rd(s, v);
    chk(v, e);
endtask
task automatic end_sim;
    $display("mismatches %0d, checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0)
        $display("Run complete: PASS");
    else
        $display("Run complete: FAIL");
    $finish;
endtask
// Sources held 320 ns, then the load finishes
task automatic trig(input logic [4:0] m, input logic [1:0] s,
                    input logic [23:0] a);
    src = m;
    repeat (16) @(negedge clk);
    src = 5'h00;
    chk(master_state, 2'h2);
    chk(boot_address, a);
    load_done = 1'b1;
    @(negedge clk);
    load_done = 1'b0;
    repeat (2) @(negedge clk);
    chk(master_state, s);
endtask
initial
begin
    repeat (10000) @(posedge clk);
    n_mismatch++;
    end_sim;
end
initial
begin
    repeat (2) @(negedge clk);
    sys_rst = 1'b0;
    repeat (2) @(negedge clk);
    load_done = 1'b0;
    @(negedge clk);
    chk(master_state, 2'h0);
    rc(3'h2, `RSU_BAD_CAPTURE);
    u.wr(W);
    rc(3'h4, W);
    trig(5'h01, 2'h1, BA);
    chk({early_done_check, startup_osc_select, watchdog_enable}, 3'h7);
    rc(3'h0, {2'h1, 1'b1, 29'h1578_0008});
    rc(3'h1, {2'h1, 6'h00, BA});
    u.wr(39'h0);
    rc(3'h4, W);
    for (i = 0; i < 5; i++)
    begin
        trig(5'h10 >> i, i == 4, (i == 4) ? BA : 24'h0);
        rc(3'h2, {8'h00, 5'h10 >> i, 2'h1, BA});
        if (i == 0)
            rc(3'h4, W);
        if (i < 4)
            trig(5'h01, 2'h1, BA);
    end
    trig(5'h11, 2'h0, 24'h0);
    rc(3'h2, {8'h00, 5'h10, 2'h1, BA});
    rc(3'h3, {8'h00, 5'h01, 2'h1, BA});
    rc(3'h0, {7'h00, 2'h0, 6'h00, 24'h0});
    end_sim;
end
endmodule // tb_rsu_status_ctrl

/* inc/rsu_defs.vh */
/*
 * Constants for the remote upgrade status and control block.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef RSU_DEFS_VH
`define RSU_DEFS_VH

// Master state codes
`define RSU_ST_FACTORY   2'h0
`define RSU_ST_APP       2'h1
`define RSU_ST_RELOAD    2'h2

// Control and update register layout
`define RSU_CTL_W        39
`define RSU_CTL_ZERO     39'h00_0000_0000
`define RSU_CTL_EARLY    37
`define RSU_CTL_OSC      36
`define RSU_CTL_WDEN     35
`define RSU_CTL_ADDR_HI  33
`define RSU_CTL_ADDR_LO  12
`define RSU_CTL_WD_HI    11
`define RSU_CTL_WD_LO    0

// Padding appended to the 12-bit watchdog setting and the 22-bit address field
`define RSU_WD_LOW_PAD   17'h0_0008
`define RSU_ADDR_PAD     2'h0

// Previous-state record layout, source bits are one-hot
`define RSU_SRC_CFGRST   4
`define RSU_SRC_CRC      3
`define RSU_SRC_STATUS   2
`define RSU_SRC_WDOG     1
`define RSU_SRC_FABRIC   0
`define RSU_BAD_CAPTURE  31'h7FFF_FFFF

// Capture selector codes
`define RSU_RD_CUR1      3'h0
`define RSU_RD_CUR2      3'h1
`define RSU_RD_PREV1     3'h2
`define RSU_RD_PREV2     3'h3
`define RSU_RD_CTL       3'h4

// Least width of the fabric request, clock period in ps
`define RSU_REQ_MIN_NS   250
`define RSU_CLK_PS       20000

`endif

/* logic/rsu_status_ctrl.v */
/*
 * Remote upgrade status and control: master state machine, control,
 * update and status records, and the user shift register.
 * Assumes all control inputs except load_done arrive asynchronously from user logic or
 * pins and that the shift clock is far slower than clk.
 */
// Behaviour
// - Status records the cause of reconfiguration from application
// - Factory view: state, zero pad, boot address
// - Application view one: state, wd enable, timeout
// - Two previous-state records, newest and older
// - One-hot source field in bits 30:26
// - Simultaneous sources: highest bit wins
// - Records hold master state and boot address
// - Early previous capture returns a marker value
// - Control and update share one layout
// - Update/control writes only in factory configuration
// - Fabric request copies update into control
// - Triggers steer control toward factory or application
// - Errors clear control; fabric request loads update
// - Status written before the reload begins
// - Shift and update paced by the shift clock
// - Capture loads status into the shift register
`timescale 1ns/100ps
`include "rsu_defs.vh"

module rsu_status_ctrl
(
    input  wire        clk,                // System clock, 50 MHz
    input  wire        sys_rst,            // Synchronous reset, high
    input  wire        upgrade_shift_clock, // User shift clock
    input  wire        shift_data_in,      // Serial data from user
    input  wire        shift_select,       // 1 shift, 0 capture/update
    input  wire        capture_select,     // 1 capture, 0 update
    input  wire [2:0]  read_select,        // Word chosen at capture
    input  wire        fabric_reconfig_request, // User reload request
    input  wire        crc_error,          // CRC error during load
    input  wire        config_status_line_n, // External error, low
    input  wire        ext_config_reset_n, // External reset, low
    input  wire        watchdog_expired,   // Watchdog time-out
    input  wire        load_done,          // Image load finished
    output reg         shift_data_out,     // Serial data to user
    output reg         reconfig_start,     // Pulse: begin image load
    output wire [1:0]  master_state,       // Current master state
    output wire [23:0] boot_address,       // Address of the image
    output wire        watchdog_enable,    // Watchdog enable in use
    output wire [28:0] watchdog_timeout,   // Watchdog reload value
    output wire        early_done_check,   // Early done check option
    output wire        startup_osc_select  // Startup oscillator opt
);

localparam NSYNC = 9;

////////////////////////////////////////////////////////////////////////
// Input synchronisers
wire [NSYNC-1:0] async_in;
reg  [NSYNC-1:0] sync1_reg;
reg  [NSYNC-1:0] sync2_reg;
reg  [NSYNC-1:0] sync3_reg;

assign async_in = {upgrade_shift_clock, shift_data_in, shift_select,
                   capture_select, fabric_reconfig_request, crc_error,
                   ~config_status_line_n, ~ext_config_reset_n,
                   watchdog_expired};

// Third stage only feeds edge detection
genvar gi;
generate
    for (gi = 0; gi < NSYNC; gi = gi + 1)
    begin : g_sync
        always @(posedge clk)
        begin
            if (sys_rst)
            begin
                sync1_reg[gi] <= 1'b0;
                sync2_reg[gi] <= 1'b0;
                sync3_reg[gi] <= 1'b0;
            end
            else
            begin
                sync1_reg[gi] <= async_in[gi];
                sync2_reg[gi] <= sync1_reg[gi];
                sync3_reg[gi] <= sync2_reg[gi];
            end
        end
    end
endgenerate

// Selector is quasi-static but still crosses from the user's domain
reg  [2:0]       rsel1_reg;
reg  [2:0]       rsel2_reg;

always @(posedge clk)
begin
    if (sys_rst)
    begin
        rsel1_reg <= 3'h0;
        rsel2_reg <= 3'h0;
    end
    else
    begin
        rsel1_reg <= read_select;
        rsel2_reg <= rsel1_reg;
    end
end

wire s_clk_rise = sync2_reg[8] & ~sync3_reg[8];
wire s_din      = sync2_reg[7];
wire s_shift    = sync2_reg[6];
wire s_capture  = sync2_reg[5];
wire fab_rise   = sync2_reg[4] & ~sync3_reg[4];
wire crc_ev     = sync2_reg[3] & ~sync3_reg[3];
wire stat_ev    = sync2_reg[2] & ~sync3_reg[2];
wire rst_ev     = sync2_reg[1] & ~sync3_reg[1];
wire wd_ev      = sync2_reg[0] & ~sync3_reg[0];

////////////////////////////////////////////////////////////////////////
// Master state machine and records
reg  [1:0]            state_reg;
reg  [1:0]            target_reg;
reg  [`RSU_CTL_W-1:0] control_reg;
reg  [`RSU_CTL_W-1:0] update_reg;
reg  [30:0]           prev1_reg;
reg  [30:0]           prev2_reg;
reg                   app_seen_reg;
reg  [4:0]            src_next;

wire [23:0] ctl_addr = {control_reg[`RSU_CTL_ADDR_HI:`RSU_CTL_ADDR_LO],
                        `RSU_ADDR_PAD};
wire running  = (state_reg == `RSU_ST_FACTORY) ||
                (state_reg == `RSU_ST_APP);
wire any_trig = rst_ev | crc_ev | stat_ev | wd_ev | fab_rise;

// Highest source bit wins a tie
always @*
begin
    src_next = 5'h00;
    if (rst_ev)
        src_next[`RSU_SRC_CFGRST] = 1'b1;
    else if (crc_ev)
        src_next[`RSU_SRC_CRC] = 1'b1;
    else if (stat_ev)
        src_next[`RSU_SRC_STATUS] = 1'b1;
    else if (wd_ev)
        src_next[`RSU_SRC_WDOG] = 1'b1;
    else if (fab_rise)
        src_next[`RSU_SRC_FABRIC] = 1'b1;
end

// Fabric request must win no tie, so it only steers when alone
wire fab_only = fab_rise & ~(rst_ev | crc_ev | stat_ev | wd_ev);

always @(posedge clk)
begin
    if (sys_rst)
    begin
        state_reg      <= `RSU_ST_RELOAD;
        target_reg     <= `RSU_ST_FACTORY;
        control_reg    <= `RSU_CTL_ZERO;
        prev1_reg      <= 31'h0000_0000;
        prev2_reg      <= 31'h0000_0000;
        app_seen_reg   <= 1'b0;
        reconfig_start <= 1'b1;
    end
    else
    begin
        reconfig_start <= 1'b0;
        case (state_reg)
            `RSU_ST_FACTORY, `RSU_ST_APP:
            begin
                if (any_trig)
                begin
                    // Record the exit before the reload starts
                    if (state_reg == `RSU_ST_APP)
                    begin
                        prev2_reg <= prev1_reg;
                        prev1_reg <= {src_next, state_reg,
                                      ctl_addr};
                    end
                    // Request width is assumed to span the sync chain
                    if (fab_only)
                    begin
                        control_reg <= update_reg;
                        target_reg  <= `RSU_ST_APP;
                    end
                    else
                    begin
                        control_reg <= `RSU_CTL_ZERO;
                        target_reg  <= `RSU_ST_FACTORY;
                    end
                    state_reg      <= `RSU_ST_RELOAD;
                    reconfig_start <= 1'b1;
                end
            end
            `RSU_ST_RELOAD:
            begin
                if (load_done)
                begin
                    state_reg <= target_reg;
                    if (target_reg == `RSU_ST_APP)
                        app_seen_reg <= 1'b1;
                end
            end
            default:
            begin
                state_reg <= `RSU_ST_RELOAD;
            end
        endcase
    end
end

assign master_state       = state_reg;
assign boot_address       = ctl_addr;
assign watchdog_enable    = control_reg[`RSU_CTL_WDEN];
assign watchdog_timeout   = {control_reg[`RSU_CTL_WD_HI:`RSU_CTL_WD_LO],
                             `RSU_WD_LOW_PAD};
assign early_done_check   = control_reg[`RSU_CTL_EARLY];
assign startup_osc_select = control_reg[`RSU_CTL_OSC];

////////////////////////////////////////////////////////////////////////
// Capture source selection
reg  [`RSU_CTL_W-1:0] cap_word;
wire in_app = (state_reg == `RSU_ST_APP);

always @*
begin
    cap_word = `RSU_CTL_ZERO;
    case (rsel2_reg)
        `RSU_RD_CUR1:
        begin
            if (in_app)
                cap_word[31:0] = {state_reg, watchdog_enable,
                                  watchdog_timeout};
            else
                cap_word[31:0] = {state_reg, 6'h00, ctl_addr};
        end
        `RSU_RD_CUR2:
            cap_word[31:0] = {state_reg, 6'h00, ctl_addr};
        `RSU_RD_PREV1:
            cap_word[30:0] = app_seen_reg ? prev1_reg
                                          : `RSU_BAD_CAPTURE;
        `RSU_RD_PREV2:
            cap_word[30:0] = app_seen_reg ? prev2_reg
                                          : `RSU_BAD_CAPTURE;
        `RSU_RD_CTL:
            cap_word = in_app ? control_reg : update_reg;
        default:
            cap_word = `RSU_CTL_ZERO;
    endcase
end

////////////////////////////////////////////////////////////////////////
// Shift and update registers, paced by shift clock rising edges
reg [`RSU_CTL_W-1:0] shift_reg;

always @(posedge clk)
begin
    if (sys_rst)
    begin
        shift_reg      <= `RSU_CTL_ZERO;
        update_reg     <= `RSU_CTL_ZERO;
        shift_data_out <= 1'b0;
    end
    else
    begin
        if (s_clk_rise)
        begin
            if (s_shift)
                shift_reg <= {s_din, shift_reg[`RSU_CTL_W-1:1]};
            else if (s_capture)
                shift_reg <= cap_word;
            else if (state_reg == `RSU_ST_FACTORY)
                update_reg <= shift_reg;
        end
        shift_data_out <= shift_reg[0];
    end
end

endmodule // rsu_status_ctrl
